// ---- src/psd_consts.vh ----
// Constants of the power swing sequencer: register offsets, field positions,
// reset values of the settings and the millisecond time base.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
`ifndef PSD_CONSTS_VH
`define PSD_CONSTS_VH

// Register byte offsets.
`define PSD_OFF_CTRL      8'h00
`define PSD_OFF_SUPV      8'h04
`define PSD_OFF_TIME1     8'h08
`define PSD_OFF_TIME2     8'h0c
`define PSD_OFF_TIME3     8'h10
`define PSD_OFF_STATUS    8'h14

// Control register fields.
`define PSD_CTRL_ENABLE   0
`define PSD_CTRL_3STEP    1
`define PSD_CTRL_DELAYED  2
`define PSD_CTRL_TGT_LO   3
`define PSD_CTRL_TGT_HI   4
`define PSD_CTRL_EVENTS   5
`define PSD_CTRL_TGT_CLR  6
`define PSD_CTRL_RESET    7'h04

// Target indication modes.
`define PSD_TGT_SELF      2'h0
`define PSD_TGT_LATCHED   2'h1
`define PSD_TGT_OFF       2'h2

// Setting reset values, current in 0.001 pu, times in ms.
`define PSD_SUPV_RESET    16'h0258
`define PSD_PKP1_RESET    16'h001e
`define PSD_RST1_RESET    16'h0032
`define PSD_PKP2_RESET    16'h0011
`define PSD_PKP3_RESET    16'h0009
`define PSD_PKP4_RESET    16'h0011
`define PSD_SEAL_RESET    16'h0190

// Time base: clock rate in MHz and tick period in microseconds.
`define PSD_CLK_MHZ       250
`define PSD_TICK_US       1000
`define PSD_MS_CYCLES     (`PSD_CLK_MHZ * `PSD_TICK_US)

`endif

// ---- src/psd_timer.v ----
// Millisecond pickup timer used for every delay of the sequencer.
// Assumes a one-cycle tick strobe from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module psd_timer #(
    parameter W = 16
) (
    input  wire         ref_clk,
    input  wire         rstn,
    input  wire         tick,
    input  wire         run,
    input  wire [W-1:0] preset,
    output wire         done
);

    reg  [W-1:0] cnt_q;   // Elapsed milliseconds while running.
    reg  [W-1:0] cnt_d;   // Next elapsed count.

    // Expiry is immediate for a zero preset, so a zero setting means no delay.
    assign done = run & (cnt_q >= preset);

    // Count ticks while running; stop at expiry so the count never wraps.
    always @*
    begin
        if (!run)
            cnt_d = {W{1'b0}};
        else if (tick && !done)
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        else
            cnt_d = cnt_q;
    end

    // The count restarts from zero whenever the run condition drops.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= {W{1'b0}};
        else
            cnt_q <= cnt_d;
    end

endmodule

`default_nettype wire

// ---- src/psd_sequencer.v ----
// Power swing blocking and out-of-step trip sequencer with APB settings.
// Assumes zone flags, current magnitude and trip inhibit come from logic
// on ref_clk, so none of them is resynchronised.
// What this block does
// - One enable switches the whole element
// - Step mode governs blocking and tripping
// - Three-step: outer-not-middle past delay 1 blocks
// - Block clears after outer exit plus reset delay
// - Two-step blocking times outer-not-inner instead
// - Delay 1 sets stage latch while outer
// - Middle-not-inner for delay 2 sets latch 2
// - Inner for delay 3 makes ready, held
// - Early mode trips at once, sealed in
// - Delayed mode arms, trips on outer exit
// - Two-step skips the delay 2 stage
// - One current level qualifies all zones
// - Timers are 16-bit millisecond counts
// - Target mode and event recording are settable
// - Delay 4 times outer-not-inner before arming
// - Inhibit clears trip, sequence keeps running
`timescale 1ns/1ps
`default_nettype none
`include "psd_consts.vh"

module psd_sequencer #(
    parameter MS_CYCLES = `PSD_MS_CYCLES
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        outer_in,
    input  wire        middle_in,
    input  wire        inner_in,
    input  wire [15:0] i1_mag,
    input  wire        trip_inhibit_in,
    output wire        swing_block_out,
    output wire        oos_trip_out,
    output wire        target_out,
    output wire        event_pulse_out
);

    // Settings written by software.
    reg  [6:0]  ctrl_q;                     // Enable, mode, trip mode, target, events.
    reg  [15:0] current_supervision_level;  // Positive-sequence level, 0.001 pu.
    reg  [15:0] pkp1_q;                     // Pickup delay 1, ms.
    reg  [15:0] rst1_q;                     // Reset delay 1, ms.
    reg  [15:0] pkp2_q;                     // Pickup delay 2, ms.
    reg  [15:0] pkp3_q;                     // Pickup delay 3, ms.
    reg  [15:0] pkp4_q;                     // Pickup delay 4, ms.
    reg  [15:0] trip_hold_time;             // Seal-in delay, ms.

    // Sequence state.
    reg         block_q;    // Swing block latch.
    reg         latch1_q;   // First out-of-step stage.
    reg         latch2_q;   // Second out-of-step stage.
    reg         ready_q;    // Ready to trip.
    reg         arm_q;      // Delayed trip armed.
    reg         seal_q;     // Trip sealed in.
    reg         trip_q;     // Registered trip output.
    reg         tgt_q;      // Target indication.
    reg         evt_q;      // Event strobe.
    reg         block_old_q; // Block level one cycle ago, for event edges.
    reg         seal_old_q;  // Seal level one cycle ago, for event edges.

    // Millisecond strobe.
    reg  [31:0] div_q;
    reg         tick_q;

    wire        enable      = ctrl_q[`PSD_CTRL_ENABLE];
    wire        three_step  = ctrl_q[`PSD_CTRL_3STEP];
    wire        delayed     = ctrl_q[`PSD_CTRL_DELAYED];
    wire [1:0]  tgt_mode    = ctrl_q[`PSD_CTRL_TGT_HI:`PSD_CTRL_TGT_LO];
    wire        event_record_enable = ctrl_q[`PSD_CTRL_EVENTS];

    // Zones qualified by the enable and the common current level.
    wire        cur_ok  = enable & (i1_mag >= current_supervision_level);
    wire        z_outer = outer_in & cur_ok;
    wire        z_mid   = middle_in & cur_ok;
    wire        z_inner = inner_in & cur_ok;

    // First timing band: outer-not-middle in three-step, outer-not-inner in two-step.
    wire        band1   = three_step ? (z_outer & ~z_mid) : (z_outer & ~z_inner);
    wire        band2   = three_step & latch1_q & z_outer & z_mid & ~z_inner;
    wire        stage2  = three_step ? latch2_q : latch1_q;
    wire        band3   = stage2 & z_outer & z_inner;
    wire        band4   = delayed & ready_q & z_outer & ~z_inner;

    wire        t1_done;
    wire        tr_done;
    wire        t2_done;
    wire        t3_done;
    wire        t4_done;
    wire        ts_done;

    // Trip starts: early at the moment of readiness, delayed at outer exit.
    wire        ready_set   = t3_done & ~ready_q;
    wire        early_fire  = ~delayed & ready_set;
    wire        delay_fire  = delayed & arm_q & ~z_outer;

    // APB access decode; the slave answers with no wait state.
    wire        wr_en   = psel & penable & pwrite;
    wire        hit     = (paddr == `PSD_OFF_CTRL)  | (paddr == `PSD_OFF_SUPV) |
                          (paddr == `PSD_OFF_TIME1) | (paddr == `PSD_OFF_TIME2) |
                          (paddr == `PSD_OFF_TIME3) | (paddr == `PSD_OFF_STATUS);
    wire        tgt_clr = wr_en & (paddr == `PSD_OFF_CTRL) & pwdata[`PSD_CTRL_TGT_CLR];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    assign swing_block_out = block_q;
    assign oos_trip_out    = trip_q;
    assign target_out      = tgt_q;
    assign event_pulse_out = evt_q;

    // The divider counts are kept wide so simulation can shorten the strobe freely.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_q  <= 32'h0;
            tick_q <= 1'b0;
        end
        else if (div_q >= MS_CYCLES - 1)
        begin
            div_q  <= 32'h0;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // Pickup delay 1 runs while the locus sits in the first band.
    psd_timer #(.W(16)) u_t1 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick_q),
        .run     (band1),
        .preset  (pkp1_q),
        .done    (t1_done)
    );

    // Reset delay 1 runs once the locus has left the outer zone with a block held.
    psd_timer #(.W(16)) u_tr (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick_q),
        .run     (block_q & ~z_outer),
        .preset  (rst1_q),
        .done    (tr_done)
    );

    // Pickup delay 2, three-step mode only.
    psd_timer #(.W(16)) u_t2 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick_q),
        .run     (band2),
        .preset  (pkp2_q),
        .done    (t2_done)
    );

    // Pickup delay 3 times the stay inside the inner zone.
    psd_timer #(.W(16)) u_t3 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick_q),
        .run     (band3),
        .preset  (pkp3_q),
        .done    (t3_done)
    );

    // Pickup delay 4 times the return between inner and outer before arming.
    psd_timer #(.W(16)) u_t4 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick_q),
        .run     (band4),
        .preset  (pkp4_q),
        .done    (t4_done)
    );

    // Seal-in timer holds the trip for the configured interval.
    psd_timer #(.W(16)) u_ts (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick_q),
        .run     (seal_q),
        .preset  (trip_hold_time),
        .done    (ts_done)
    );

    // Register writes; all settings but the control bits are 16-bit millisecond or 0.001 pu fields.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q                    <= `PSD_CTRL_RESET;
            current_supervision_level <= `PSD_SUPV_RESET;
            pkp1_q                    <= `PSD_PKP1_RESET;
            rst1_q                    <= `PSD_RST1_RESET;
            pkp2_q                    <= `PSD_PKP2_RESET;
            pkp3_q                    <= `PSD_PKP3_RESET;
            pkp4_q                    <= `PSD_PKP4_RESET;
            trip_hold_time            <= `PSD_SEAL_RESET;
        end
        else if (wr_en)
        begin
            case (paddr)
                `PSD_OFF_CTRL:
                    ctrl_q <= {1'b0, pwdata[5:0]};
                `PSD_OFF_SUPV:
                    current_supervision_level <= pwdata[15:0];
                `PSD_OFF_TIME1:
                begin
                    pkp1_q <= pwdata[15:0];
                    rst1_q <= pwdata[31:16];
                end
                `PSD_OFF_TIME2:
                begin
                    pkp2_q <= pwdata[15:0];
                    pkp3_q <= pwdata[31:16];
                end
                `PSD_OFF_TIME3:
                begin
                    pkp4_q         <= pwdata[15:0];
                    trip_hold_time <= pwdata[31:16];
                end
                default:
                    ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero and flag an error.
    always @*
    begin
        case (paddr)
            `PSD_OFF_CTRL:   prdata = {25'h0, ctrl_q};
            `PSD_OFF_SUPV:   prdata = {16'h0, current_supervision_level};
            `PSD_OFF_TIME1:  prdata = {rst1_q, pkp1_q};
            `PSD_OFF_TIME2:  prdata = {pkp3_q, pkp2_q};
            `PSD_OFF_TIME3:  prdata = {trip_hold_time, pkp4_q};
            `PSD_OFF_STATUS: prdata = {20'h0, z_inner, z_mid, z_outer, tgt_q, trip_q,
                                       seal_q, arm_q, ready_q, latch2_q, latch1_q,
                                       cur_ok, block_q};
            default:         prdata = 32'h0;
        endcase
    end

    // Sequence latches. Disabling clears them in a branch of its own; the qualified
    // zones drop with the enable, but the reset delay and seal-in timers run one cycle more.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            block_q  <= 1'b0;
            latch1_q <= 1'b0;
            latch2_q <= 1'b0;
            ready_q  <= 1'b0;
            arm_q    <= 1'b0;
            seal_q   <= 1'b0;
        end
        else if (!enable)
        begin
            block_q  <= 1'b0;
            latch1_q <= 1'b0;
            latch2_q <= 1'b0;
            ready_q  <= 1'b0;
            arm_q    <= 1'b0;
            seal_q   <= 1'b0;
        end
        else
        begin
            // Blocking is set by delay 1 and dropped only by the reset delay.
            if (t1_done)
                block_q <= 1'b1;
            else if (tr_done)
                block_q <= 1'b0;

            // Stage latches live only while the locus stays inside outer.
            if (!z_outer)
            begin
                latch1_q <= 1'b0;
                latch2_q <= 1'b0;
                ready_q  <= 1'b0;
                arm_q    <= 1'b0;
            end
            else
            begin
                if (t1_done)
                    latch1_q <= 1'b1;
                if (t2_done)
                    latch2_q <= 1'b1;
                if (t3_done)
                    ready_q <= 1'b1;
                if (t4_done)
                    arm_q <= 1'b1;
            end

            // The seal-in starts from either trip source and runs to expiry.
            if (early_fire || delay_fire)
                seal_q <= 1'b1;
            else if (ts_done)
                seal_q <= 1'b0;
        end
    end

    // Trip output is masked by the inhibit, which leaves the sequence untouched.
    // The enable masks it too, so a disable during a seal-in drops the trip at
    // the same edge as the latches instead of one cycle later.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            trip_q <= 1'b0;
        else
            trip_q <= seal_q & enable & ~trip_inhibit_in;
    end

    // Target and event indication; a latched target set wins over its clear.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tgt_q       <= 1'b0;
            evt_q       <= 1'b0;
            block_old_q <= 1'b0;
            seal_old_q  <= 1'b0;
        end
        else
        begin
            block_old_q <= block_q;
            seal_old_q  <= seal_q;
            evt_q <= event_record_enable &
                     ((block_q & ~block_old_q) | (seal_q & ~seal_old_q));
            case (tgt_mode)
                `PSD_TGT_SELF:
                    tgt_q <= block_q | seal_q;
                `PSD_TGT_LATCHED:
                begin
                    if (block_q || seal_q)
                        tgt_q <= 1'b1;
                    else if (tgt_clr)
                        tgt_q <= 1'b0;
                end
                default:
                    tgt_q <= 1'b0;
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- dv/psd_seq_sva.sv ----
// Port checker of the swing sequencer, bound to every psd_sequencer.
// Assumes the settings change only through writes on the APB port.
`timescale 1ns/1ps
`default_nettype none
`include "psd_consts.vh"

module psd_seq_sva (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        outer_in,
    input wire logic        middle_in,
    input wire logic        inner_in,
    input wire logic [15:0] i1_mag,
    input wire logic        trip_inhibit_in,
    input wire logic        swing_block_out,
    input wire logic        oos_trip_out,
    input wire logic        event_pulse_out
);
    logic        en_q;                                       // Mirrored enable bit.
    logic        th_q;                                       // Mirrored three-step bit.
    logic        dl_q;                                       // Mirrored delayed-trip bit.
    logic [15:0] supv_q;                                     // Mirrored current level.
    wire         wr_w   = psel && penable && pwrite && pready;
    wire         oq_w   = outer_in && (i1_mag >= supv_q);
    wire         band_w = outer_in && !(th_q ? middle_in : inner_in);

    // Settings mirror, so the checks follow mode changes without probing the body.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            en_q   <= 1'b0;
            th_q   <= 1'b0;
            dl_q   <= 1'b1;
            supv_q <= `PSD_SUPV_RESET;
        end
        else if (wr_w && paddr == `PSD_OFF_CTRL)
        begin
            en_q <= pwdata[0];
            th_q <= pwdata[1];
            dl_q <= pwdata[2];
        end
        else if (wr_w && paddr == `PSD_OFF_SUPV)
            supv_q <= pwdata[15:0];
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    blk_hold_a: assert property ($fell(swing_block_out) && en_q |-> !$past(oq_w) && !$past(oq_w, 2))
        else $error("block dropped while the locus was inside the outer zone");
    blk_mode_a: assert property ($rose(swing_block_out) |-> $past(band_w, 2))
        else $error("block rose without the timed band of the selected mode");
    trip_inh_a: assert property (trip_inhibit_in |=> !oos_trip_out)
        else $error("trip output high under inhibit");
    dis_clr_a: assert property (!en_q |=> !swing_block_out && !oos_trip_out)
        else $error("outputs active while the element is off");
    // Unaligned offsets are unmapped as well as those past the status word.
    apb_err_a: assert property (psel && penable |-> pready &&
        (pslverr == (paddr > `PSD_OFF_STATUS || paddr[1:0] != 2'h0)))
        else $error("bus answer wrong for this address");
    // A rise that only follows the inhibit's release is not a new trip start.
    trip_early_a: assert property ($rose(oos_trip_out) && !dl_q &&
        !$past(trip_inhibit_in, 2) |-> $past(inner_in, 3))
        else $error("early trip without inner dwell");
    trip_dly_a: assert property ($rose(oos_trip_out) && dl_q &&
        !$past(trip_inhibit_in, 2) |-> !$past(oq_w) || !$past(oq_w, 2) || !$past(oq_w, 3))
        else $error("delayed trip not at outer exit");
    evt_pulse_a: assert property (event_pulse_out |=> !event_pulse_out)
        else $error("event pulse longer than one cycle");
endmodule

bind psd_sequencer psd_seq_sva u_sva (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .outer_in(outer_in), .middle_in(middle_in), .inner_in(inner_in),
    .i1_mag(i1_mag), .trip_inhibit_in(trip_inhibit_in), .swing_block_out(swing_block_out),
    .oos_trip_out(oos_trip_out), .event_pulse_out(event_pulse_out));
`default_nettype wire

// ---- dv/psd_zone_src.sv ----
// Stand-in for the impedance stage: nested zone flags for a locus band.
// Assumes the bench names the band (0 out, 1 outer, 2 middle, 3 inner).
`timescale 1ns/1ps
`default_nettype none

module psd_zone_src (
    input  wire logic       ref_clk,
    input  wire logic [1:0] depth,
    output var  logic       outer_q,
    output var  logic       middle_q,
    output var  logic       inner_q
);
    // One register stage like real measurement logic; zones are always nested.
    always @(posedge ref_clk)
    begin
        outer_q  <= depth != 2'h0;
        middle_q <= depth[1];
        inner_q  <= depth == 2'h3;
    end
endmodule
`default_nettype wire

// ---- dv/power_swing_oos_sequencer_tb_top.sv ----
// Self-checking bench of the swing sequencer through APB and zone flags.
// Assumes a 4-cycle millisecond tick so every delay stays short.
`timescale 1ns/1ps
`default_nettype none
`include "psd_consts.vh"

module power_swing_oos_sequencer_tb_top;
    localparam int MS = 4;                     // Clocks per millisecond tick.
    logic        ref_clk, rstn, psel, penable, pwrite, trip_inhibit_in, er;
    logic        pready, pslverr, outer_in, middle_in, inner_in;
    logic        swing_block_out, oos_trip_out, target_out, event_pulse_out;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] i1_mag;
    logic [1:0]  depth;
    int          err_total, n_compared, ev_n, cyc_n, n;
    logic [31:0] rv [5] = '{32'h4, 32'h258, 32'h32001e, 32'h90011, 32'h1900011};

    psd_sequencer #(.MS_CYCLES(MS)) dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .outer_in(outer_in), .middle_in(middle_in),
        .inner_in(inner_in), .i1_mag(i1_mag), .trip_inhibit_in(trip_inhibit_in),
        .swing_block_out(swing_block_out), .oos_trip_out(oos_trip_out),
        .target_out(target_out), .event_pulse_out(event_pulse_out));
    psd_zone_src zs (.ref_clk(ref_clk), .depth(depth), .outer_q(outer_in),
        .middle_q(middle_in), .inner_q(inner_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Counts event pulses; the cycle ceiling stops a hung run.
    always @(posedge ref_clk)
    begin
        cyc_n = cyc_n + 1;
        if (event_pulse_out === 1'b1)
            ev_n = ev_n + 1;
        if (cyc_n == 20000)
        begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end

    task tally_and_finish;
    begin
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    // One APB transfer; the request stands until pready is seen at an edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    // Moves the locus to a band, then lets c cycles pass.
    task zone(input logic [1:0] d, input int c);
    begin
        @(posedge ref_clk);
        depth <= d;
        repeat (c) @(negedge ref_clk);
    end
    endtask

    // Waits, bounded, for block (s=0) or trip (s=1) to reach level v.
    task wt(input int s, input logic v);
    begin
        n = 0;
        while ((s ? oos_trip_out : swing_block_out) !== v && n < 200)
        begin
            @(negedge ref_clk);
            n = n + 1;
        end
    end
    endtask

    initial
    begin
        {rstn, psel, penable, pwrite, trip_inhibit_in, paddr, pwdata, depth} = '0;
        i1_mag = 16'h00c8;
        {err_total, n_compared, ev_n, cyc_n} = '0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset_value", rv[i], rd);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_rd", 32'h0, rd);
        apb(1'b1, `PSD_OFF_SUPV, 32'h64);
        apb(1'b1, `PSD_OFF_TIME1, 32'h40003);
        apb(1'b1, `PSD_OFF_TIME2, 32'h20002);
        apb(1'b1, `PSD_OFF_TIME3, 32'h50002);
        apb(1'b0, `PSD_OFF_TIME1, 32'h0);
        chk("time1", 32'h40003, rd);
        // Middle band blocks only in two-step mode.
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, `PSD_OFF_CTRL, 32'(1 + 2 * m));
            zone(2'h2, 6 * MS);
            chk("band_block", 32'(1 - m), swing_block_out);
            zone(2'h0, 8 * MS);
        end
        chk("events_off", 0, ev_n);
        apb(1'b1, `PSD_OFF_CTRL, 32'h23);
        zone(2'h1, 0);
        wt(0, 1'b1);
        chk("block_delay", 1, n >= 2 * MS && n <= 4 * MS + 4);
        zone(2'h2, 4 * MS);
        zone(2'h3, 0);
        wt(1, 1'b1);
        chk("early_trip", 1, n >= MS && n <= 3 * MS + 4);
        zone(2'h3, 4);
        @(posedge ref_clk) trip_inhibit_in <= 1'b1;
        zone(2'h3, 2);
        chk("inhibit", 0, oos_trip_out);
        @(posedge ref_clk) trip_inhibit_in <= 1'b0;
        zone(2'h3, 2);
        chk("seq_runs", 1, oos_trip_out);
        wt(1, 1'b0);
        chk("seal_len", 1, n + 11 >= 4 * MS && n + 11 <= 6 * MS + 4);
        chk("events_on", 1, ev_n > 0);
        zone(2'h0, 8 * MS);
        // Delayed, two-step, latched target: arm after leaving inner.
        apb(1'b1, `PSD_OFF_CTRL, 32'h0d);
        zone(2'h1, 5 * MS);
        zone(2'h3, 4 * MS);
        chk("no_early", 0, oos_trip_out);
        zone(2'h1, 4 * MS);
        zone(2'h0, 0);
        wt(1, 1'b1);
        chk("delayed_trip", 1, n <= 4);
        wt(1, 1'b0);
        chk("delayed_seal", 0, oos_trip_out);
        chk("dly_seal_len", 1, n >= 4 * MS && n <= 6 * MS + 4);
        zone(2'h0, 8 * MS);
        chk("target_held", 1, target_out);
        apb(1'b1, `PSD_OFF_CTRL, 32'h4d);
        zone(2'h0, 2);
        chk("target_clr", 0, target_out);
        // Current one step under the level does not qualify.
        apb(1'b1, `PSD_OFF_CTRL, 32'h03);
        @(posedge ref_clk) i1_mag <= 16'h0063;
        zone(2'h1, 6 * MS);
        chk("supv_low", 0, swing_block_out);
        @(posedge ref_clk) i1_mag <= 16'h0064;
        wt(0, 1'b1);
        chk("supv_edge", 1, n >= 2 * MS && n <= 4 * MS + 4);
        zone(2'h1, 2);
        chk("target_self", 1, target_out);
        // Target indication off: the block stays, the target drops.
        apb(1'b1, `PSD_OFF_CTRL, 32'h13);
        zone(2'h1, 2);
        chk("target_off", 0, target_out);
        chk("block_kept", 1, swing_block_out);
        apb(1'b1, `PSD_OFF_CTRL, 32'h0);
        zone(2'h1, 2);
        chk("disable", 0, swing_block_out);
        tally_and_finish;
    end
endmodule
`default_nettype wire
